// ---- core/mask_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module mask_test (
   input wire logic [3:0] mem_data,
   input wire logic [3:0] mask,
   output logic all_set,
   output logic all_clear
);

   logic [3:0] set_ok;
   logic [3:0] clear_ok;

   // Unselected bits always pass, so an empty mask tests true
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_bit
         assign set_ok[i] = ~mask[i] | mem_data[i];
         assign clear_ok[i] = ~mask[i] | ~mem_data[i];
      end
   endgenerate

   assign all_set = &set_ok;
   assign all_clear = &clear_ok;

endmodule : mask_test

`default_nettype wire

// ---- core/nibble_compare.sv ----
`timescale 1ns/10ps
`default_nettype none

module nibble_compare (
   input wire logic [3:0] mem_data,
   input wire logic [3:0] imm_data,
   output logic equal,
   output logic not_equal,
   output logic greater_equal,
   output logic less
);

   // Both operands unsigned nibbles
   assign equal = (mem_data == imm_data);
   assign not_equal = (mem_data != imm_data);
   assign greater_equal = (mem_data >= imm_data);
   assign less = (mem_data < imm_data);

endmodule : nibble_compare

`default_nettype wire

// ---- core/nibble_pkg.sv ----
`default_nettype none

package nibble_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int NIBBLE_W = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] STATUS_WORD_OFFSET = 8'h00;
   localparam logic [7:0] SKIP_STATE_OFFSET = 8'h04;
   localparam logic [7:0] LAST_RESULT_OFFSET = 8'h08;

   // ************************************************************
   // Field positions of the program status word register
   // ************************************************************
   localparam int CARRY_BIT = 0;
   localparam int ZERO_BIT = 1;
   localparam int COMPARE_ONLY_BIT = 2;
   localparam int DECIMAL_BIT = 3;

   // Field positions of the skip state register
   localparam int PENDING_BIT = 0;
   localparam int LAST_SKIP_BIT = 1;

   // ************************************************************
   // Reset values and arithmetic constants
   // ************************************************************
   localparam logic CARRY_RESET = 1'b0;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic COMPARE_ONLY_RESET = 1'b0;
   localparam logic DECIMAL_RESET = 1'b0;
   localparam logic [3:0] RESULT_RESET = 4'h0;
   localparam logic [4:0] DECIMAL_LIMIT = 5'h09;
   localparam logic [4:0] DECIMAL_BASE = 5'h0A;

   // ************************************************************
   // Operation codes, one-hot
   // ************************************************************
   typedef enum logic [8:0] {
      OP_NONE = 9'h000,
      OP_SKIP_IF_ALL_SET = 9'h001,
      OP_SKIP_IF_ALL_CLEAR = 9'h002,
      OP_SKIP_IF_EQUAL = 9'h004,
      OP_SKIP_IF_NOT_EQUAL = 9'h008,
      OP_SKIP_IF_GREATER_EQUAL = 9'h010,
      OP_SKIP_IF_LESS = 9'h020,
      OP_ROTATE_RIGHT_THROUGH_CARRY = 9'h040,
      OP_ADD_WITH_CARRY = 9'h080,
      OP_OTHER = 9'h100
   } op_type;

   // Sequencer skip states, one-hot
   typedef enum logic [1:0] {
      RUNNING = 2'h1,
      SKIPPING = 2'h2
   } skip_state_type;

endpackage : nibble_pkg

`default_nettype wire

// ---- core/nibble_skip_compare_rotate_unit.sv ----
`timescale 1ns/10ps
`default_nettype none

module nibble_skip_compare_rotate_unit (
   input wire logic clk,
   input wire logic rst_n,
   // Operation from the sequencer
   input wire logic op_valid,
   input wire nibble_pkg::op_type op_code,
   input wire logic [3:0] mem_data,
   input wire logic [3:0] imm_data,
   input wire logic [3:0] reg_data,
   // Results toward sequencer and register file
   output logic skip_req,
   output logic suppressing,
   output logic reg_write,
   output logic [3:0] result_data,
   output logic carry_flag,
   output logic zero_flag,
   output logic compare_only_flag,
   output logic decimal_flag,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);

   // ************************************************************
   // Operation decode
   // ************************************************************
   nibble_pkg::skip_state_type state;
   nibble_pkg::skip_state_type next_state;

   logic mask_all_set;
   logic mask_all_clear;
   logic cmp_equal;
   logic cmp_not_equal;
   logic cmp_greater_equal;
   logic cmp_less;

   wire in_skip = (state == nibble_pkg::SKIPPING);
   // A skipped instruction is consumed here and never executes
   wire active = op_valid & ~in_skip;
   // Unknown codes decode to nothing yet still use up a pending skip
   wire do_all_set = active & (op_code == nibble_pkg::OP_SKIP_IF_ALL_SET);
   wire do_all_clear = active & (op_code == nibble_pkg::OP_SKIP_IF_ALL_CLEAR);
   wire do_equal = active & (op_code == nibble_pkg::OP_SKIP_IF_EQUAL);
   wire do_not_equal = active & (op_code == nibble_pkg::OP_SKIP_IF_NOT_EQUAL);
   wire do_greater_equal = active & (op_code == nibble_pkg::OP_SKIP_IF_GREATER_EQUAL);
   wire do_less = active & (op_code == nibble_pkg::OP_SKIP_IF_LESS);
   wire do_rotate = active & (op_code == nibble_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY);
   wire do_add = active & (op_code == nibble_pkg::OP_ADD_WITH_CARRY);
   wire do_bit_test = do_all_set | do_all_clear;

   // ************************************************************
   // Evaluation units
   // ************************************************************
   // Bit tests see the memory nibble only; no register path exists
   mask_test u_mask_test (
      .mem_data(mem_data),
      .mask(imm_data),
      .all_set(mask_all_set),
      .all_clear(mask_all_clear)
   );

   // Compares see memory against immediate only
   nibble_compare u_compare (
      .mem_data(mem_data),
      .imm_data(imm_data),
      .equal(cmp_equal),
      .not_equal(cmp_not_equal),
      .greater_equal(cmp_greater_equal),
      .less(cmp_less)
   );

   // One qualified term per evaluation
   wire hit_all_set = do_all_set & mask_all_set;
   wire hit_all_clear = do_all_clear & mask_all_clear;
   wire hit_equal = do_equal & cmp_equal;
   wire hit_not_equal = do_not_equal & cmp_not_equal;
   wire hit_greater_equal = do_greater_equal & cmp_greater_equal;
   wire hit_less = do_less & cmp_less;
   wire skip_hit = hit_all_set | hit_all_clear | hit_equal
      | hit_not_equal | hit_greater_equal | hit_less;

   // ************************************************************
   // Rotate right through carry
   // ************************************************************
   wire [3:0] rotate_result = {carry_flag, reg_data[3:1]};
   wire rotate_carry = reg_data[0];

   // ************************************************************
   // Add with carry
   // ************************************************************
   // Register plus memory plus carry; with memory equal to the
   // register and decimal mode off this is the left rotate through carry
   wire [4:0] add_sum = {1'b0, reg_data} + {1'b0, mem_data} + {4'h0, carry_flag};
   // Decimal correction only holds for sums up to 19
   wire add_over = decimal_flag & (add_sum > nibble_pkg::DECIMAL_LIMIT);
   wire [4:0] add_corrected = add_sum - nibble_pkg::DECIMAL_BASE;
   wire [3:0] add_result = add_over ? add_corrected[3:0] : add_sum[3:0];
   wire add_carry = add_over | add_sum[4];
   wire add_is_zero = (add_result == 4'h0);
   // Compare-only keeps zero on a zero result, clears it otherwise
   wire add_zero = compare_only_flag ? (add_is_zero & zero_flag) : add_is_zero;

   // ************************************************************
   // Register port decode
   // ************************************************************
   // Writes to any other offset are dropped
   wire wr_status = wr & (addr == nibble_pkg::STATUS_WORD_OFFSET);
   wire rd_status = rd & (addr == nibble_pkg::STATUS_WORD_OFFSET);
   wire rd_skip = rd & (addr == nibble_pkg::SKIP_STATE_OFFSET);
   wire rd_result = rd & (addr == nibble_pkg::LAST_RESULT_OFFSET);

   logic last_skip;
   logic [3:0] last_result;

   wire [31:0] status_word = {28'h0000000,
                              decimal_flag,
                              compare_only_flag,
                              zero_flag,
                              carry_flag};
   // Bit 0 follows the live suppression state
   wire [31:0] skip_word = {30'h0, last_skip, in_skip};
   wire [31:0] result_word = {28'h0000000, last_result};
   // Unmapped addresses read as zero
   wire [31:0] next_rdata = rd_status ? status_word :
                            rd_skip ? skip_word :
                            rd_result ? result_word : 32'h00000000;

   // ************************************************************
   // Flag next values
   // ************************************************************
   // Field values carried by a status write
   wire written_carry = wdata[nibble_pkg::CARRY_BIT];
   wire written_zero = wdata[nibble_pkg::ZERO_BIT];
   wire written_compare_only = wdata[nibble_pkg::COMPARE_ONLY_BIT];
   wire written_decimal = wdata[nibble_pkg::DECIMAL_BIT];

   // Instruction effects take priority over a software write in the
   // same cycle, so no hardware update is lost
   wire next_carry = do_rotate ? rotate_carry :
                     do_add ? add_carry :
                     wr_status ? written_carry :
                     carry_flag;
   wire next_zero = do_add ? add_zero :
                    wr_status ? written_zero :
                    zero_flag;
   wire next_compare_only = do_bit_test ? 1'b0 :
                            wr_status ? written_compare_only :
                            compare_only_flag;
   // Decimal mode changes only by a software write
   wire next_decimal = wr_status ? written_decimal : decimal_flag;

   // Rotate stores regardless of compare-only; add honours it
   wire next_reg_write = do_rotate | (do_add & ~compare_only_flag);
   wire [3:0] next_result = do_rotate ? rotate_result :
                            do_add ? add_result : result_data;
   wire do_eval = do_bit_test | do_equal | do_not_equal | do_greater_equal | do_less;

   // ************************************************************
   // Skip state machine
   // ************************************************************
   always_comb begin
      next_state = state;
      case (state)
         nibble_pkg::RUNNING: begin
            if (skip_hit) begin
               next_state = nibble_pkg::SKIPPING;
            end
         end
         nibble_pkg::SKIPPING: begin
            // The fetched instruction is dropped as a no-operation
            if (op_valid) begin
               next_state = nibble_pkg::RUNNING;
            end
         end
         default: begin
            // Recovers from an illegal state code
            next_state = nibble_pkg::RUNNING;
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // One short process per register keeps each reset value beside
   // the update that it guards
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= nibble_pkg::RUNNING;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_req <= 1'b0;
      end else begin
         skip_req <= skip_hit;
      end
   end

   // A swallowed instruction leaves the last outcome alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_skip <= 1'b0;
      end else if (do_eval) begin
         last_skip <= skip_hit;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carry_flag <= nibble_pkg::CARRY_RESET;
      end else begin
         carry_flag <= next_carry;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_flag <= nibble_pkg::ZERO_RESET;
      end else begin
         zero_flag <= next_zero;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_only_flag <= nibble_pkg::COMPARE_ONLY_RESET;
      end else begin
         compare_only_flag <= next_compare_only;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         decimal_flag <= nibble_pkg::DECIMAL_RESET;
      end else begin
         decimal_flag <= next_decimal;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_write <= 1'b0;
      end else begin
         reg_write <= next_reg_write;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_data <= nibble_pkg::RESULT_RESET;
      end else begin
         result_data <= next_result;
      end
   end

   // Only rotate and add update the readable result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_result <= nibble_pkg::RESULT_RESET;
      end else if (do_rotate | do_add) begin
         last_result <= next_result;
      end
   end

   // Read data stands for one cycle, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign suppressing = in_skip;

endmodule : nibble_skip_compare_rotate_unit

`default_nettype wire

// ---- tb/nibble_skip_compare_rotate_unit_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

module nibble_skip_compare_rotate_unit_tb;
   logic clk;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0, wr = 1'b0, rd = 1'b0, preset_en = 1'b0;
   nibble_pkg::op_type op_code = nibble_pkg::OP_NONE;
   logic [3:0] mem_data = 4'h0, imm_data = 4'h0, preset_value = 4'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] reg_data, result_data;
   logic skip_req, suppressing, reg_write, carry_flag, zero_flag, compare_only_flag, decimal_flag;
   logic [31:0] rdata;
   int miscompares = 0, total_checks = 0, cycles = 0;

   nibble_skip_compare_rotate_unit i_dut (.clk, .rst_n, .op_valid, .op_code, .mem_data, .imm_data, .reg_data,
      .skip_req, .suppressing, .reg_write, .result_data, .carry_flag, .zero_flag, .compare_only_flag,
      .decimal_flag, .addr, .wdata, .wr, .rd, .rdata);
   reg_file_model i_reg_file (.clk, .rst_n, .preset_en, .preset_value, .reg_write, .result_data, .reg_data);

   // ********************************
   // Rows: op, follow op, reg, mem, imm, status in, skip, reg out, status out
   // ********************************
   // Op index n means one-hot bit n; F means no op
   logic [35:0] rows [27] = '{
      36'h0F0BB4100, 36'h0F0BD3003, 36'h0F0500100,
      36'h1F096F10B, 36'h1F09E0000,
      36'h2F0AAF10F, 36'h2F0A80000, 36'h3F0A86106, 36'h3F0AA0000,
      36'h4F0870100, 36'h4F0880100, 36'h4F0890000,
      36'h5F0890100, 36'h5F0880000, 36'h5F0870000,
      36'h6F80010C0, 36'h6F3006017, 36'h6F3008019,
      36'h7F9901031, 36'h8F5000050,
      36'h268331181, 36'h3683310C0, 36'h020FF0100,
      36'h7F0000002, 36'h7F5A06054, 36'h7F8806087,
      36'h7F7508029};

   task automatic run_row(input logic [35:0] r);
      @(posedge clk);
      wr <= 1'b1;
      addr <= nibble_pkg::STATUS_WORD_OFFSET;
      wdata <= {28'h0, r[15:12]};
      preset_en <= 1'b1;
      preset_value <= r[27:24];
      @(posedge clk);
      wr <= 1'b0;
      preset_en <= 1'b0;
      op_valid <= 1'b1;
      op_code <= nibble_pkg::op_type'(9'h001 << r[35:32]);
      mem_data <= r[23:20];
      imm_data <= r[19:16];
      @(posedge clk);
      op_code <= nibble_pkg::op_type'(9'h001 << r[31:28]);
      @(negedge clk);
      `CHECK("skip_req", r[8], skip_req)
      `CHECK("suppressing", r[8], suppressing)
      @(posedge clk);
      op_valid <= 1'b0;
      @(negedge clk);
      `CHECK("skip_after", 1'b0, skip_req)
      // Write-back of an op taken in the follow slot lands one edge later
      @(posedge clk);
      @(negedge clk);
      `CHECK("reg", r[7:4], reg_data)
      `CHECK("status", r[3:0], {decimal_flag, compare_only_flag, zero_flag, carry_flag})
   endtask : run_row

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHECK("rdata", exp, rdata)
   endtask : reg_read

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Whole run is about 160 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHECK("reset status", 4'h0, {decimal_flag, compare_only_flag, zero_flag, carry_flag})
      `CHECK("reset skip", 1'b0, skip_req)
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      reg_read(nibble_pkg::STATUS_WORD_OFFSET, 32'h9);
      reg_read(nibble_pkg::LAST_RESULT_OFFSET, 32'h2);
      reg_read(8'h10, 32'h0);
      // Bit test against a status write in the same cycle
      @(posedge clk);
      wr <= 1'b1;
      addr <= nibble_pkg::STATUS_WORD_OFFSET;
      wdata <= 32'h0000000F;
      op_valid <= 1'b1;
      op_code <= nibble_pkg::OP_SKIP_IF_ALL_SET;
      mem_data <= 4'h0;
      imm_data <= 4'h0;
      @(posedge clk);
      wr <= 1'b0;
      op_valid <= 1'b0;
      @(negedge clk);
      `CHECK("write vs test", 4'hB, {decimal_flag, compare_only_flag, zero_flag, carry_flag})
      `CHECK("empty mask skip", 1'b1, skip_req)
      reg_read(nibble_pkg::SKIP_STATE_OFFSET, 32'h3);
      // Reset in the middle of a pending skip
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHECK("mid reset status", 4'h0, {decimal_flag, compare_only_flag, zero_flag, carry_flag})
      `CHECK("mid reset suppress", 1'b0, suppressing)
      reg_read(nibble_pkg::SKIP_STATE_OFFSET, 32'h0);
      finish_test();
   end
endmodule : nibble_skip_compare_rotate_unit_tb

`default_nettype wire

// ---- tb/nibble_unit_checker_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module nibble_unit_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire nibble_pkg::op_type op_code,
   input wire logic [3:0] mem_data,
   input wire logic [3:0] imm_data,
   input wire logic [3:0] reg_data,
   input wire logic skip_req,
   input wire logic suppressing,
   input wire logic reg_write,
   input wire logic [3:0] result_data,
   input wire logic carry_flag,
   input wire logic zero_flag,
   input wire logic compare_only_flag,
   input wire logic decimal_flag,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Codes are one-hot, so one bit names an executed op
   wire logic [8:0] op = (op_valid && !suppressing && !wr) ? op_code : 9'h000;
   logic [3:0] prev_mem;
   logic [3:0] prev_imm;
   logic [3:0] prev_reg;
   logic prev_carry;
   always_ff @(posedge clk) begin
      prev_mem <= mem_data;
      prev_imm <= imm_data;
      prev_reg <= reg_data;
      prev_carry <= carry_flag;
   end
   a_all_set_skip: assert property (op[0] |=> skip_req == ((prev_mem & prev_imm) == prev_imm))
      else $error("all-set skip wrong");
   a_all_clear_skip: assert property (op[1] |=> skip_req == ((prev_mem & prev_imm) == 4'h0))
      else $error("all-clear skip wrong");
   a_equal_skip: assert property (op[2] |=> skip_req == (prev_mem == prev_imm))
      else $error("equal skip wrong");
   a_not_equal_skip: assert property (op[3] |=> skip_req == (prev_mem != prev_imm))
      else $error("not-equal skip wrong");
   a_greater_skip: assert property (op[4] |=> skip_req == (prev_mem >= prev_imm))
      else $error("greater-or-equal skip wrong");
   a_less_skip: assert property (op[5] |=> skip_req == (prev_mem < prev_imm))
      else $error("less skip wrong");
   a_compare_flags_kept: assert property (|op[5:2] |=> $stable(carry_flag) && $stable(zero_flag) && !reg_write)
      else $error("compare changed flags");
   a_bit_test_flags: assert property (|op[1:0] |=> !compare_only_flag && $stable(carry_flag) && $stable(zero_flag))
      else $error("bit test flags wrong");
   a_rotate_right: assert property (op[6] |=> result_data == {prev_carry, prev_reg[3:1]} && carry_flag == prev_reg[0])
      else $error("rotate result wrong");
   a_rotate_zero_kept: assert property (op[6] |=> reg_write && $stable(zero_flag))
      else $error("rotate zero or write wrong");
   a_add_rotate_left:
      assert property (op[7] && mem_data == reg_data && !compare_only_flag && !decimal_flag
         |=> reg_write && result_data == {prev_reg[2:0], prev_carry} && carry_flag == prev_reg[3])
      else $error("left rotation by add wrong");
   a_suppressed_op: assert property (op_valid && suppressing && !wr |=> !skip_req && !reg_write && !suppressing)
      else $error("suppressed op had effect");
   a_skip_suppresses: assert property (skip_req |-> suppressing ##1 !skip_req)
      else $error("skip without suppression");
   c_skip_then_op: cover property (skip_req && op_valid);
   c_rotate: cover property (op[6]);
   c_add: cover property (op[7]);
endmodule : nibble_unit_checker

bind nibble_skip_compare_rotate_unit nibble_unit_checker i_checker (.clk, .rst_n, .op_valid, .op_code,
   .mem_data, .imm_data, .reg_data, .skip_req, .suppressing, .reg_write, .result_data, .carry_flag,
   .zero_flag, .compare_only_flag, .decimal_flag, .addr, .wdata, .wr, .rd, .rdata);

`default_nettype wire

// ---- tb/reg_file_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module reg_file_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic preset_en,
   input wire logic [3:0] preset_value,
   input wire logic reg_write,
   input wire logic [3:0] result_data,
   output logic [3:0] reg_data
);
   // Write-back wins, so a preset never hides a missed write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_data <= 4'h0;
      end else if (reg_write) begin
         reg_data <= result_data;
      end else if (preset_en) begin
         reg_data <= preset_value;
      end
   end
endmodule : reg_file_model

`default_nettype wire
